// ### include/tmr16_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of
  the 16-bit timer/counter. Assumes an 8-bit register port whose
  addresses are the printed offsets.
*/
`ifndef TMR16_REGS_SVH
`define TMR16_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TMR16_OFS_GLOB_CTL 8'h0B
`define TMR16_OFS_FLAG     8'h0C
`define TMR16_OFS_CNT_LO   8'h0E
`define TMR16_OFS_CNT_HI   8'h0F
`define TMR16_OFS_CTRL     8'h10
`define TMR16_OFS_ENABLE   8'h8C

// ----------------------------------------------------------------------
// Fields, reset values, timing
// ----------------------------------------------------------------------
`define TMR16_OVF_BIT      0
`define TMR16_CTRL_MASK    8'h3F
`define TMR16_CTRL_RST     8'h00
`define TMR16_FLAG_RST     1'b0
`define TMR16_GLOB_CTL_RST 8'h00
`define TMR16_SEVT_CODE    4'hB
`define TMR16_CNT_MAX      16'hFFFF
`define TMR16_INSTR_DIV    4

`endif

// ### include/tmr16_pkg.sv
/*
  Types of the 16-bit timer/counter: control layout, compare unit view
  and the count source selection. Assumes tmr16_regs.svh for numbers.
*/
package tmr16_pkg;

  // ----------------------------------------------------------------------
  // Control register layout, bit 7 down to bit 0
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic       oscillator_enable;
    logic       sync_control;
    logic       clock_source_select;
    logic       run_enable;
  } tmr16_ctrl_type;

  // Compare unit view seen by the timer
  typedef struct packed {
    logic [3:0]  compare_mode_field;
    logic [15:0] compare_value;
  } tmr16_cmp_type;

  typedef enum logic [3:0] {
    SRC_OFF   = 4'b0001,
    SRC_TIMER = 4'b0010,
    SRC_SYNC  = 4'b0100,
    SRC_ASYNC = 4'b1000
  } tmr16_src_type;

endpackage

// ### rtl/tmr16_top.sv
/*
  16-bit timer/counter with prescaler, overflow interrupt and compare
  special-event reset. Assumes the register master keeps one-cycle
  strobes and that all pin inputs are synchronous to sys_clk_in.
*/
`timescale 1ns/1ps
`include "tmr16_regs.svh"

module tmr16_top
  import tmr16_pkg::*;
#(
  parameter int INSTR_DIV = `TMR16_INSTR_DIV
)
(
  input  wire logic          sys_clk_in,
  input  wire logic          reset_in,
  input  wire logic          other_reset_in,
  input  wire logic [7:0]    reg_addr_in,
  input  wire logic [7:0]    reg_wdata_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  output logic      [7:0]    reg_rdata_out,
  input  wire tmr16_cmp_type cmp_one_in,
  input  wire tmr16_cmp_type cmp_two_in,
  input  wire logic          ext_clock_pin_in,
  input  wire logic [1:0]    pin_direction_c_in,
  output logic      [1:0]    pin_dir_eff_out,
  output logic               sevt_out,
  output logic               irq_out
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  tmr16_ctrl_type ctrl_r;
  tmr16_src_type  src;
  logic [15:0]    cnt_r;
  logic [7:0]     glob_ctl_r;
  logic [7:0]     rd_nxt;
  logic [7:0]     rdata_r;
  logic [$clog2(INSTR_DIV)-1:0] div_r;
  logic [2:0]     presc_r;
  logic           instr_en;
  logic           ext_prev_r;
  logic           ext_edge;
  logic           src_tick;
  logic           presc_hit;
  logic           sync_pend_r;
  logic           inc;
  logic           sevt;
  logic           ovf_set;
  logic           flag_r;
  logic           ie_r;
  logic           sevt_r;
  logic           wr_lo;
  logic           wr_hi;
  logic           wr_cnt;
  logic           wr_ctrl;
  logic           wr_flag;
  logic           wr_ie;
  logic           wr_glob_ctl;
  logic           rd_flag;

  function automatic logic [2:0] presc_mask(input logic [1:0] sel);
    presc_mask = 3'(4'(1) << sel) - 3'h1;
  endfunction

  function automatic logic cmp_match(input tmr16_cmp_type c,
                                     input logic [15:0] v);
    cmp_match = (c.compare_mode_field == `TMR16_SEVT_CODE) &&
                (c.compare_value == v);
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign wr_lo     = reg_wr_in && (reg_addr_in == `TMR16_OFS_CNT_LO);
  assign wr_hi     = reg_wr_in && (reg_addr_in == `TMR16_OFS_CNT_HI);
  assign wr_cnt    = wr_lo || wr_hi;
  assign wr_ctrl   = reg_wr_in && (reg_addr_in == `TMR16_OFS_CTRL);
  assign wr_flag   = reg_wr_in && (reg_addr_in == `TMR16_OFS_FLAG);
  assign wr_ie     = reg_wr_in && (reg_addr_in == `TMR16_OFS_ENABLE);
  assign wr_glob_ctl = reg_wr_in && (reg_addr_in == `TMR16_OFS_GLOB_CTL);
  assign rd_flag   = reg_rd_in && (reg_addr_in == `TMR16_OFS_FLAG);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  // Only power-on reset touches it; other_reset_in leaves it alone
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      ctrl_r <= tmr16_ctrl_type'(`TMR16_CTRL_RST);
    else if (wr_ctrl)
      ctrl_r <= tmr16_ctrl_type'(reg_wdata_in & `TMR16_CTRL_MASK);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      glob_ctl_r <= `TMR16_GLOB_CTL_RST;
    else if (other_reset_in)
      glob_ctl_r <= `TMR16_GLOB_CTL_RST;
    else if (wr_glob_ctl)
      glob_ctl_r <= reg_wdata_in;
  end

  assign pin_dir_eff_out = ctrl_r.oscillator_enable ? 2'b11
                                                    : pin_direction_c_in;

  // ----------------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------------
  // Four system clocks make one instruction cycle
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      div_r <= '0;
    else if (instr_en)
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign instr_en = (div_r == ($clog2(INSTR_DIV))'(INSTR_DIV - 1));

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= ext_clock_pin_in;
  end

  assign ext_edge = ext_clock_pin_in && !ext_prev_r;

  always_comb
  begin
    if (!ctrl_r.run_enable)
      src = SRC_OFF;
    else if (!ctrl_r.clock_source_select)
      src = SRC_TIMER;
    else if (ctrl_r.sync_control)
      src = SRC_ASYNC;
    else
      src = SRC_SYNC;
  end

  always_comb
  begin
    case (src)
      SRC_TIMER: src_tick = instr_en;
      SRC_SYNC:  src_tick = ext_edge;
      SRC_ASYNC: src_tick = ext_edge;
      default:   src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  assign presc_hit = src_tick &&
    ((presc_r & presc_mask(ctrl_r.prescale_select)) ==
     presc_mask(ctrl_r.prescale_select));

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      presc_r <= 3'h0;
    else if (wr_cnt)
      presc_r <= 3'h0;
    else if (src_tick)
      presc_r <= presc_r + 3'h1;
  end

  // Synchronized path waits for the instruction-cycle boundary
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      sync_pend_r <= 1'b0;
    else if (src != SRC_SYNC || instr_en)
      sync_pend_r <= 1'b0;
    else if (presc_hit)
      sync_pend_r <= 1'b1;
  end

  always_comb
  begin
    case (src)
      SRC_TIMER: inc = presc_hit;
      SRC_SYNC:  inc = (sync_pend_r || presc_hit) && instr_en;
      SRC_ASYNC: inc = presc_hit;
      default:   inc = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Count and special event
  // ----------------------------------------------------------------------
  // Match resets on the next advance, so period is compare value plus one
  assign sevt = inc && (cmp_match(cmp_one_in, cnt_r) ||
                        cmp_match(cmp_two_in, cnt_r));

  // No reset: the count keeps its value through every reset
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_lo)
      cnt_r[7:0] <= reg_wdata_in;
    else if (wr_hi)
      cnt_r[15:8] <= reg_wdata_in;
    else if (sevt)
      cnt_r <= 16'h0000;
    else if (inc)
      cnt_r <= cnt_r + 16'h0001;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      sevt_r <= 1'b0;
    else
      sevt_r <= sevt;
  end

  assign sevt_out = sevt_r;

  // ----------------------------------------------------------------------
  // Overflow flag and interrupt
  // ----------------------------------------------------------------------
  assign ovf_set = inc && !sevt && !wr_cnt &&
                   (cnt_r == `TMR16_CNT_MAX);

  // Hardware set beats a same-cycle read or write clear
  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      flag_r <= `TMR16_FLAG_RST;
    else if (ovf_set)
      flag_r <= 1'b1;
    else if (other_reset_in)
      flag_r <= `TMR16_FLAG_RST;
    else if (wr_flag)
      flag_r <= reg_wdata_in[`TMR16_OVF_BIT];
    else if (rd_flag)
      flag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      ie_r <= 1'b0;
    else if (other_reset_in)
      ie_r <= 1'b0;
    else if (wr_ie)
      ie_r <= reg_wdata_in[`TMR16_OVF_BIT];
  end

  assign irq_out = flag_r && ie_r;

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_nxt = 8'h00;
    if (reg_addr_in == `TMR16_OFS_CNT_LO)
      rd_nxt = cnt_r[7:0];
    else if (reg_addr_in == `TMR16_OFS_CNT_HI)
      rd_nxt = cnt_r[15:8];
    else if (reg_addr_in == `TMR16_OFS_CTRL)
      rd_nxt = ctrl_r;
    else if (reg_addr_in == `TMR16_OFS_FLAG)
      rd_nxt = {7'h00, flag_r};
    else if (reg_addr_in == `TMR16_OFS_ENABLE)
      rd_nxt = {7'h00, ie_r};
    else if (reg_addr_in == `TMR16_OFS_GLOB_CTL)
      rd_nxt = glob_ctl_r;
  end

  always_ff @(posedge sys_clk_in or posedge reset_in)
  begin
    if (reset_in)
      rdata_r <= 8'h00;
    else if (reg_rd_in)
      rdata_r <= rd_nxt;
    else
      rdata_r <= 8'h00;
  end

  assign reg_rdata_out = rdata_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_ext_rise;
    !ext_clock_pin_in ##1 ext_clock_pin_in;
  endsequence

  sequence s_plain_adv;
    !wr_cnt && !sevt && cnt_r != `TMR16_CNT_MAX;
  endsequence

  AST_WRAP_FLAG: assert property (
    inc && !sevt && !wr_cnt && cnt_r == `TMR16_CNT_MAX
    |=> flag_r && cnt_r == 16'h0000)
    else $error("wrap did not set overflow flag");

  AST_FLAG_HOLD: assert property (
    flag_r && !wr_flag && !rd_flag && !other_reset_in |=> flag_r)
    else $error("overflow flag dropped on its own");

  AST_IRQ_MASK: assert property (
    !ie_r && !wr_ie |=> !irq_out)
    else $error("interrupt raised while disabled");

  AST_IRQ_RAISE: assert property (
    ovf_set && ie_r && !wr_ie && !other_reset_in |=> irq_out)
    else $error("enabled overflow gave no interrupt");

  AST_STOP_HOLD: assert property (
    !ctrl_r.run_enable && !wr_cnt |=> cnt_r == $past(cnt_r))
    else $error("count moved while stopped");

  AST_TIMER_RATE: assert property (
    src == SRC_TIMER && ctrl_r.prescale_select == 2'b00 && instr_en
    ##0 s_plain_adv |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("timer missed an instruction cycle");

  AST_EXT_EDGE: assert property (
    s_ext_rise ##0 (src == SRC_ASYNC && ctrl_r.prescale_select == 2'b00)
    ##0 s_plain_adv |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("external edge not counted");

  AST_SEVT_ZERO: assert property (
    sevt && !wr_cnt |=> cnt_r == 16'h0000 && sevt_out)
    else $error("special event did not zero count");

  AST_SEVT_NOFLAG: assert property (
    sevt && !flag_r && !wr_flag |=> !flag_r)
    else $error("special event set overflow flag");

  AST_WRITE_WINS: assert property (
    wr_lo && sevt |=> cnt_r[7:0] == $past(reg_wdata_in))
    else $error("special event beat count write");

  AST_PRESC_CLR: assert property (
    wr_cnt |=> presc_r == 3'h0)
    else $error("count write left prescaler set");

  AST_OSC_PINS: assert property (
    ctrl_r.oscillator_enable |-> pin_dir_eff_out == 2'b11)
    else $error("oscillator pins not forced to input");

endmodule

// ### tb/tmr16_ext_src.sv
/*
  Model of the external count clock source feeding the counter pin.
  Assumes a caller that starts bursts between sys_clk_in edges.
*/
`timescale 1ns/1ps
module tmr16_ext_src
(
  input  wire logic sys_clk_in,
  output logic      ext_clock_out
);
  // Idles low between bursts, like a gated source
  initial ext_clock_out = 1'b0;

  task automatic emit(input int edges, input int half);
    repeat (edges)
    begin
      @(posedge sys_clk_in);
      ext_clock_out <= 1'b1;
      repeat (half) @(posedge sys_clk_in);
      ext_clock_out <= 1'b0;
      repeat (half - 1) @(posedge sys_clk_in);
    end
  endtask
endmodule

// ### tb/tmr16_top_test.sv
/*
  Self-checking bench of the 16-bit timer/counter with a count model.
  Assumes tmr16_pkg compiled first and tmr16_regs.svh on the path.
*/
`timescale 1ns/1ps
`include "tmr16_regs.svh"
module tmr16_top_test
  import tmr16_pkg::*;
;
  localparam int         IDIV  = 4;
  localparam int         LIMIT = 20000;
  localparam logic [7:0] LO    = `TMR16_OFS_CNT_LO;
  localparam logic [7:0] HI    = `TMR16_OFS_CNT_HI;
  localparam logic [7:0] CTRL  = `TMR16_OFS_CTRL;
  localparam logic [7:0] FLAG  = `TMR16_OFS_FLAG;
  localparam logic [7:0] ENA   = `TMR16_OFS_ENABLE;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          oth = 1'b0;
  logic [7:0]    addr = 8'h00;
  logic [7:0]    wd = 8'h00;
  logic          wr = 1'b0;
  logic          rd = 1'b0;
  logic [7:0]    rdata;
  tmr16_cmp_type c1 = '0;
  tmr16_cmp_type c2 = '0;
  logic          ext;
  logic [1:0]    pdir = 2'b00;
  logic [1:0]    pdo;
  logic          sevt;
  logic          irq;
  logic [7:0]    d;
  logic [7:0]    v;
  logic [15:0]   cv;
  int            num_errors = 0;
  int            n_compared = 0;
  int            sevt_seen = 0;
  int            cycles = 0;
  int            m_cnt;
  int            m_flag = 0;
  int            md;
  int            s0;

  always #12.5 clk = ~clk;

  tmr16_top #(.INSTR_DIV(IDIV)) tmr16_top_inst (
    .sys_clk_in(clk), .reset_in(rst), .other_reset_in(oth),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .cmp_one_in(c1),
    .cmp_two_in(c2), .ext_clock_pin_in(ext),
    .pin_direction_c_in(pdir), .pin_dir_eff_out(pdo),
    .sevt_out(sevt), .irq_out(irq));

  tmr16_ext_src tmr16_ext_src_inst (.sys_clk_in(clk), .ext_clock_out(ext));

  always @(posedge clk)
  begin
    cycles++;
    if (sevt === 1'b1)
      sevt_seen++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------------
  // Bus, model and checks
  // --------------------------------------------------------------------
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wd <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(d, e);
  endtask

  task automatic setcnt(input logic [15:0] x);
    wreg(LO, x[7:0]);
    wreg(HI, x[15:8]);
    m_cnt = x;
  endtask

  task automatic getcnt;
    rchk(LO, m_cnt[7:0]);
    rchk(HI, m_cnt[15:8]);
  endtask

  // Window of exactly t instruction cycles between the two writes
  task automatic run(input logic [1:0] ps, input int t);
    wreg(CTRL, {2'b00, ps, 4'h1});
    cyc(t * IDIV - 2);
    wreg(CTRL, 8'h00);
  endtask

  task automatic model(input int n, input int c, input bit se);
    repeat (n)
    begin
      if (se && m_cnt == c)
        m_cnt = 0;
      else
      begin
        m_flag |= (m_cnt == 16'hFFFF);
        m_cnt = (m_cnt + 1) % 65536;
      end
    end
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial
  begin
    void'($urandom(53));
    // Count has no reset; load it while reset holds so checks see no X
    setcnt(16'($urandom));
    rst <= 1'b0;
    rchk(CTRL, 8'h00);
    rchk(FLAG, 8'h00);
    rchk(ENA, 8'h00);
    v = 8'($urandom);
    wreg(`TMR16_OFS_GLOB_CTL, v);
    rchk(`TMR16_OFS_GLOB_CTL, v);
    wreg(8'h55, 8'hFF);
    rchk(8'h55, 8'h00);
    wreg(ENA, 8'hFF);
    rchk(ENA, 8'h01);
    wreg(CTRL, 8'hFC);
    rchk(CTRL, 8'h3C);
    @(posedge clk);
    pdir <= 2'($urandom);
    cyc(1);
    #1 chk(pdo, 2'b11);
    setcnt(16'($urandom));
    @(posedge clk);
    oth <= 1'b1;
    @(posedge clk);
    oth <= 1'b0;
    rchk(CTRL, 8'h3C);
    rchk(ENA, 8'h00);
    getcnt();
    wreg(CTRL, 8'h00);
    #1 chk(pdo, pdir);
    // Each run's setcnt write clears the prescaler that the previous run left dirty
    for (int i = 0; i < 8; i++)
    begin
      setcnt(16'($urandom));
      run(2'(i >> 1), (5 << (i >> 1)) + (1 << (i >> 1)) - 1);
      model(5, 0, 0);
      getcnt();
      cyc(20);
      getcnt();
    end
    wreg(FLAG, 8'h00);
    wreg(ENA, 8'h00);
    m_flag = 0;
    setcnt(16'hFFFE);
    run(2'd0, 3);
    model(3, 0, 0);
    getcnt();
    chk(irq, 1'b0);
    wreg(ENA, 8'h01);
    #1 chk(irq, 1'b1);
    rchk(FLAG, 8'(m_flag));
    chk(irq, 1'b0);
    rchk(FLAG, 8'h00);
    setcnt(16'hFFFF);
    run(2'd0, 1);
    #1 chk(irq, 1'b1);
    rchk(FLAG, 8'h01);
    m_flag = 0;
    for (int u = 0; u < 3; u++)
    begin
      md = (u == 2) ? $urandom % 11 : 11;
      cv = 16'($urandom & 16'h7FFF) + 16'h0004;
      @(posedge clk);
      c1 <= (u != 1) ? {4'(md), cv} : '0;
      c2 <= (u == 1) ? {4'(md), cv} : '0;
      s0 = sevt_seen;
      setcnt(cv - 16'h0004);
      run(2'd0, 12);
      model(12, cv, md == 11);
      getcnt();
      rchk(FLAG, 8'h00);
      chk(16'(sevt_seen - s0), 16'(md == 11));
    end
    // Count writes landing on special events; gap flips write phase
    cv = {8'h00, 8'($urandom)};
    @(posedge clk);
    c1 <= {4'hB, cv};
    setcnt(cv);
    wreg(CTRL, 8'h01);
    for (int w = 0; w < 8; w++)
    begin
      if (w == 4)
        cyc(1);
      wreg(LO, cv[7:0]);
    end
    wreg(CTRL, 8'h00);
    c1 <= '0;
    rchk(HI, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      md = (p + 1) % 2;
      setcnt(16'($urandom));
      wreg(CTRL, {2'b00, 2'(p), 1'b0, 1'(md), 2'b11});
      tmr16_ext_src_inst.emit(3 << p, md ? $urandom_range(1, 3) : 4);
      cyc(12);
      wreg(CTRL, 8'h00);
      model(3, 0, 0);
      getcnt();
    end
    wreg(CTRL, 8'h30);
    @(posedge clk);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    rchk(CTRL, 8'h00);
    getcnt();
    wrap_up();
  end
endmodule
